/* File: hdl/pci_config_header_regs.sv */
/*
  configuration header slice of the 1394 host controller function:
  class/revision, tenure limit and line size, header layout and self-test,
  and the memory window base with its address decode.
  assumes dword configuration cycles with byte enables, one request per
  cycle at most, and the command register living outside this block.
  every request is answered one cycle later; unmapped dwords read zero
  and swallow writes. the memory response enable level comes from the
  command register, and the initiator engine supplies frame and grant.
*/
`timescale 1ns/1ps
module pci_config_header_regs #(
  parameter logic [7:0] SILICON_REVISION = 8'h5a, // arbitrary value
  parameter int         TENURE_W         = 8,
  parameter int         LINE_SIZE_W      = 8
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  // configuration access
  input  wire logic                cfg_rd,
  input  wire logic                cfg_wr,
  input  wire logic [7:0]          cfg_addr,
  input  wire logic [3:0]          cfg_byte_en,
  input  wire logic [31:0]         cfg_wdata,
  output logic      [31:0]         cfg_rdata_q,
  output logic                     cfg_ack_q,
  // memory window decode
  input  wire logic                memory_response_enable,
  input  wire logic                mem_valid,
  input  wire logic [31:0]         mem_addr,
  output logic                     window_hit_q,
  output logic      [10:0]         window_offset_q,
  // initiator side
  input  wire logic                frame_start,
  input  wire logic                xfer_active,
  input  wire logic                gnt_n,
  input  wire logic                line_cmd_req,
  output logic                     line_cmd_ok_q,
  output logic      [TENURE_W-1:0] tenure_count_q,
  output logic                     tenure_expired_q,
  output logic                     xfer_stop_q,
  // settings for the rest of the function
  output logic [LINE_SIZE_W-1:0]   line_size_setting_q,
  output logic [TENURE_W-1:0]      tenure_limit_q,
  output logic [20:0]              window_base_pointer_q
);

  // one-hot access decode; combinational, and compared as a whole value downstream
  typedef enum logic [2:0] {
    ACC_IDLE  = 3'b001,
    ACC_READ  = 3'b010,
    ACC_WRITE = 3'b100
  } acc_state_t;

  acc_state_t  acc_d;
  logic [31:0] rd_word;
  logic [7:0]  acc_dword;
  logic        wr_tenure_line;
  logic        wr_window_base;

  if (TENURE_W != 8 || LINE_SIZE_W != 8) begin : g_width_check
    $error("pci_config_header_regs: tenure and line size fields are 8 bits");
  end

  // catch a package edit that no longer tiles the base register
  if (cfg_hdr_pkg::WINDOW_PTR_LSB + cfg_hdr_pkg::WINDOW_PTR_W != 32) begin : g_ptr_span_check
    $error("pci_config_header_regs: window pointer must reach bit 31");
  end

  if ($bits(cfg_hdr_pkg::WINDOW_SIZE_BITS) + $bits(cfg_hdr_pkg::WINDOW_PREFETCH) +
      $bits(cfg_hdr_pkg::WINDOW_LOC_TYPE) + $bits(cfg_hdr_pkg::WINDOW_SPACE_MEM)
      != cfg_hdr_pkg::WINDOW_PTR_LSB) begin : g_low_bits_check
    $error("pci_config_header_regs: fixed low bits must fill up to the pointer");
  end

  if ($bits(cfg_hdr_pkg::WINDOW_PTR_RESET) != cfg_hdr_pkg::WINDOW_PTR_W) begin : g_ptr_reset_check
    $error("pci_config_header_regs: pointer reset value has the wrong width");
  end

  if ($bits(cfg_hdr_pkg::LINE_SIZE_RESET) != LINE_SIZE_W ||
      $bits(cfg_hdr_pkg::TENURE_RESET) != TENURE_W) begin : g_reset_width_check
    $error("pci_config_header_regs: field reset values have the wrong width");
  end

  // lane merges below assume each field fills one whole byte lane
  if (cfg_hdr_pkg::LINE_SIZE_LSB % 8 != 0 || cfg_hdr_pkg::TENURE_LSB % 8 != 0 ||
      cfg_hdr_pkg::HEADER_LAYOUT_LSB % 8 != 0 || cfg_hdr_pkg::SELFTEST_LSB % 8 != 0) begin : g_lane_check
    $error("pci_config_header_regs: tenure word fields must sit on byte lanes");
  end

  // the decoders compare whole dwords, so every decoded offset is aligned
  if (cfg_hdr_pkg::OFS_CLASS_REV % 4 != 0 || cfg_hdr_pkg::OFS_TENURE_LINE % 4 != 0 ||
      cfg_hdr_pkg::OFS_WINDOW_BASE % 4 != 0) begin : g_offset_check
    $error("pci_config_header_regs: decoded offsets must be dword aligned");
  end

  // ==========================================================
  // helpers
  function automatic logic [7:0] dword_of(input logic [7:0] a);
    dword_of = {a[7:2], 2'b00};
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en);
    merge_byte = en ? new_v : old_v;
  endfunction

  function automatic logic [31:0] class_word(input logic [7:0] rev);
    class_word = '0;
    class_word[cfg_hdr_pkg::CLASS_CAT_LSB +: 8]  = cfg_hdr_pkg::FUNCTION_CATEGORY;
    class_word[cfg_hdr_pkg::SUBCLASS_LSB +: 8]   = cfg_hdr_pkg::SUBCLASS_CODE;
    class_word[cfg_hdr_pkg::PROG_MODEL_LSB +: 8] = cfg_hdr_pkg::PROG_MODEL_CODE;
    class_word[cfg_hdr_pkg::REVISION_LSB +: 8]   = rev;
  endfunction

  // header layout and self-test ride in the upper half of the same dword
  function automatic logic [31:0] tenure_word(input logic [7:0] line_size,
                                              input logic [7:0] limit);
    tenure_word = '0;
    tenure_word[cfg_hdr_pkg::LINE_SIZE_LSB +: 8]     = line_size;
    tenure_word[cfg_hdr_pkg::TENURE_LSB +: 8]        = limit;
    tenure_word[cfg_hdr_pkg::HEADER_LAYOUT_LSB +: 8] = cfg_hdr_pkg::HEADER_LAYOUT;
    tenure_word[cfg_hdr_pkg::SELFTEST_LSB +: 8]      = cfg_hdr_pkg::SELFTEST_VALUE;
  endfunction

  function automatic logic [31:0] window_word(input logic [20:0] ptr);
    window_word = {ptr,
                   cfg_hdr_pkg::WINDOW_SIZE_BITS,
                   cfg_hdr_pkg::WINDOW_PREFETCH,
                   cfg_hdr_pkg::WINDOW_LOC_TYPE,
                   cfg_hdr_pkg::WINDOW_SPACE_MEM};
  endfunction

  function automatic logic in_window(input logic [31:0] a,
                                     input logic [20:0] ptr);
    in_window = (a[31:cfg_hdr_pkg::WINDOW_PTR_LSB] == ptr);
  endfunction

  // ==========================================================
  // access decode
  // write takes priority if a bus model ever raises both strobes
  always_comb begin
    acc_dword = dword_of(cfg_addr);
    if (cfg_wr) begin
      acc_d = ACC_WRITE;
    end else if (cfg_rd) begin
      acc_d = ACC_READ;
    end else begin
      acc_d = ACC_IDLE;
    end
  end

  // ==========================================================
  // write decode
  // read-only and unmapped dwords get no select, so their writes vanish
  always_comb begin
    wr_tenure_line = 1'b0;
    wr_window_base = 1'b0;
    if (acc_d == ACC_WRITE) begin
      if (acc_dword == cfg_hdr_pkg::OFS_TENURE_LINE) begin
        wr_tenure_line = 1'b1;
      end else if (acc_dword == cfg_hdr_pkg::OFS_WINDOW_BASE) begin
        wr_window_base = 1'b1;
      end
    end
  end

  // ==========================================================
  // read mux
  // offset 0eh shares the dword at 0ch, so both halves come together
  always_comb begin
    if (acc_dword == cfg_hdr_pkg::OFS_CLASS_REV) begin
      rd_word = class_word(SILICON_REVISION);
    end else if (acc_dword == cfg_hdr_pkg::OFS_TENURE_LINE) begin
      rd_word = tenure_word(line_size_setting_q, tenure_limit_q);
    end else if (acc_dword == cfg_hdr_pkg::OFS_WINDOW_BASE) begin
      rd_word = window_word(window_base_pointer_q);
    end else begin
      rd_word = '0;
    end
  end

  // ==========================================================
  // access answer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_rdata_q <= '0;
    end else if (acc_d == ACC_READ) begin
      cfg_rdata_q <= rd_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_ack_q <= 1'b0;
    end else begin
      cfg_ack_q <= (acc_d != ACC_IDLE);
    end
  end

  // ==========================================================
  // tenure limit and line size
  // bytes 2 and 3 of this dword are the fixed header/self-test pair
  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_size_setting_q <= cfg_hdr_pkg::LINE_SIZE_RESET;
    end else if (wr_tenure_line) begin
      line_size_setting_q <= merge_byte(line_size_setting_q,
                                        cfg_wdata[cfg_hdr_pkg::LINE_SIZE_LSB +: 8],
                                        cfg_byte_en[0]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tenure_limit_q <= cfg_hdr_pkg::TENURE_RESET;
    end else if (wr_tenure_line) begin
      tenure_limit_q <= merge_byte(tenure_limit_q,
                                   cfg_wdata[cfg_hdr_pkg::TENURE_LSB +: 8],
                                   cfg_byte_en[1]);
    end
  end

  // ==========================================================
  // window base pointer
  // only bits 15:11 of byte lane 1 are stored; the rest of the lane is fixed
  always_ff @(posedge clk) begin
    if (!rstn) begin
      window_base_pointer_q <= cfg_hdr_pkg::WINDOW_PTR_RESET;
    end else if (wr_window_base) begin
      if (cfg_byte_en[1]) begin
        window_base_pointer_q[4:0] <= cfg_wdata[15:11];
      end
      if (cfg_byte_en[2]) begin
        window_base_pointer_q[12:5] <= cfg_wdata[23:16];
      end
      if (cfg_byte_en[3]) begin
        window_base_pointer_q[20:13] <= cfg_wdata[31:24];
      end
    end
  end

  // ==========================================================
  // window decode
  // a zero base still decodes; software is trusted to program it first
  always_ff @(posedge clk) begin
    if (!rstn) begin
      window_hit_q <= 1'b0;
    end else begin
      window_hit_q <= mem_valid && memory_response_enable &&
        in_window(mem_addr, window_base_pointer_q);
    end
  end

  // captured on a miss too; consumers qualify it with the hit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      window_offset_q <= '0;
    end else if (mem_valid) begin
      window_offset_q <= mem_addr[10:0];
    end
  end

  // ==========================================================
  // line-based command permission
  // a zero line size leaves the engine on plain memory commands
  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_cmd_ok_q <= 1'b0;
    end else begin
      line_cmd_ok_q <= line_cmd_req && (line_size_setting_q != 8'h00);
    end
  end

  // ==========================================================
  // tenure counter
  tenure_timer #(
    .TENURE_W (TENURE_W)
  ) u_tenure (
    .clk         (clk),
    .rstn        (rstn),
    .frame_start (frame_start),
    .xfer_active (xfer_active),
    .gnt_n       (gnt_n),
    .limit       (tenure_limit_q),
    .count_q     (tenure_count_q),
    .expired_q   (tenure_expired_q),
    .stop_q      (xfer_stop_q)
  );

endmodule // pci_config_header_regs

/* File: hdl/cfg_hdr_pkg.sv */
/*
  constants for the type-0 configuration header slice of the 1394 host
  controller function: offsets, field positions, fixed codes, reset values.
  assumes the pci clock domain and dword-addressed configuration cycles.
*/
package cfg_hdr_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CLASS_REV     = 8'h08;
  localparam logic [7:0] OFS_TENURE_LINE   = 8'h0c;
  localparam logic [7:0] OFS_HDR_SELFTEST  = 8'h0e;
  localparam logic [7:0] OFS_WINDOW_BASE   = 8'h10;

  // ==========================================================
  // class and revision fields
  localparam int         CLASS_CAT_LSB     = 24;
  localparam int         SUBCLASS_LSB      = 16;
  localparam int         PROG_MODEL_LSB    = 8;
  localparam int         REVISION_LSB      = 0;
  localparam logic [7:0] FUNCTION_CATEGORY = 8'h0c;
  localparam logic [7:0] SUBCLASS_CODE     = 8'h00;
  localparam logic [7:0] PROG_MODEL_CODE   = 8'h10;

  // ==========================================================
  // tenure / line size and header / self-test fields
  localparam int         LINE_SIZE_LSB     = 0;
  localparam int         TENURE_LSB        = 8;
  localparam int         HEADER_LAYOUT_LSB = 16;
  localparam int         SELFTEST_LSB      = 24;
  localparam logic [7:0] HEADER_LAYOUT     = 8'h00;
  localparam logic [7:0] SELFTEST_VALUE    = 8'h00;
  localparam logic [7:0] LINE_SIZE_RESET   = 8'h00;
  localparam logic [7:0] TENURE_RESET      = 8'h00;

  // ==========================================================
  // window base fields
  localparam int          WINDOW_PTR_LSB    = 11;
  localparam int          WINDOW_PTR_W      = 21;
  localparam logic [20:0] WINDOW_PTR_RESET  = 21'h00000;
  localparam logic [6:0]  WINDOW_SIZE_BITS  = 7'h00;
  localparam logic        WINDOW_PREFETCH   = 1'b0;
  localparam logic [1:0]  WINDOW_LOC_TYPE   = 2'h0;
  localparam logic        WINDOW_SPACE_MEM  = 1'b0;

  // ==========================================================
  // tenure counter
  localparam logic [7:0] TENURE_COUNT_MAX  = 8'hff;

endpackage

/* File: hdl/tenure_timer.sv */
/*
  bus tenure counter for the function acting as pci initiator.
  assumes frame_start pulses in the cycle the function first drives
  frame, and xfer_active stays high until its transaction ends.
*/
`timescale 1ns/1ps
module tenure_timer #(
  parameter int TENURE_W = 8
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                frame_start,
  input  wire logic                xfer_active,
  input  wire logic                gnt_n,
  input  wire logic [TENURE_W-1:0] limit,
  output logic      [TENURE_W-1:0] count_q,
  output logic                     expired_q,
  output logic                     stop_q
);

  logic expired_d;

  if (TENURE_W != 8) begin : g_width_check
    $error("tenure_timer: TENURE_W must be 8");
  end

  // ==========================================================
  // counter
  // saturates so a long burst cannot wrap back under the limit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_q <= '0;
    end else if (frame_start) begin
      count_q <= '0;
    end else if (xfer_active && count_q != cfg_hdr_pkg::TENURE_COUNT_MAX) begin
      count_q <= count_q + 8'h01;
    end
  end

  // ==========================================================
  // expiry and stop request
  always_comb begin
    expired_d = xfer_active && !frame_start && (count_q >= limit);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      expired_q <= 1'b0;
    end else if (frame_start || !xfer_active) begin
      expired_q <= 1'b0;
    end else if (expired_d) begin
      expired_q <= 1'b1;
    end
  end

  // grant still held means the arbiter lets us run on
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= expired_q && xfer_active && gnt_n;
    end
  end

endmodule // tenure_timer

/* File: dv/cfg_host_model.sv */
/* host side model: issues config reads and writes, sets memory response.
   assumes the one-cycle acknowledge of the header slice. */
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic        clk,
  input  wire logic        cfg_ack_q,
  input  wire logic [31:0] cfg_rdata_q,
  output logic             cfg_rd,
  output logic             cfg_wr,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_byte_en,
  output logic [31:0]      cfg_wdata,
  output logic             memory_response_enable
);
  initial begin
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0;
    memory_response_enable = 1'b0;
  end
  // ==========================================================
  // one request, answer taken a cycle later; no ack gives x
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q);
    @(negedge clk);
    cfg_wr = wr;
    cfg_rd = !wr;
    cfg_addr = a;
    cfg_byte_en = be;
    cfg_wdata = d;
    @(negedge clk);
    q = cfg_ack_q ? cfg_rdata_q : 'x;
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    // released address and data lines never keep the last value; byte enables do
    cfg_addr = ~a;
    cfg_wdata = ~d;
  endtask
  task automatic enable_memory(input logic en);
    @(negedge clk);
    memory_response_enable = en;
  endtask
endmodule // cfg_host_model

/* File: dv/pci_config_header_regs_sva.sv */
/* checker for the header slice: answers, fixed fields, decode, tenure.
   assumes it is bound into the top module and sees only its ports. */
`timescale 1ns/1ps
module cfg_hdr_chk (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        cfg_rd,
  input wire logic        cfg_wr,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic        cfg_ack_q,
  input wire logic        memory_response_enable,
  input wire logic        mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic        window_hit_q,
  input wire logic [20:0] window_base_pointer_q,
  input wire logic        frame_start,
  input wire logic        xfer_active,
  input wire logic        gnt_n,
  input wire logic [7:0]  tenure_count_q,
  input wire logic        tenure_expired_q,
  input wire logic        xfer_stop_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic       rd = cfg_rd && !cfg_wr;
  wire logic [5:0] dw = cfg_addr[7:2];
  // ==========================================================
  // configuration answers
  a_ack_one_cycle: assert property ((cfg_rd || cfg_wr) |=> cfg_ack_q ##1 (cfg_ack_q == $past(cfg_rd || cfg_wr)))
    else $error("config ack not one cycle after request");
  a_class_code_read: assert property (rd && dw == 6'h02 |=> cfg_rdata_q[31:8] == 24'h0c0010)
    else $error("class bytes wrong");
  a_header_bytes_zero: assert property (rd && dw == 6'h03 |=> cfg_rdata_q[31:16] == 16'h0000)
    else $error("header or self-test byte not zero");
  a_base_low_zero: assert property (rd && dw == 6'h04 |=> cfg_rdata_q[10:0] == 11'h000)
    else $error("base low bits not zero");
  a_base_ptr_read: assert property (rd && dw == 6'h04 |=> cfg_rdata_q[31:11] == window_base_pointer_q)
    else $error("base pointer read mismatch");
  // ==========================================================
  // window decode and tenure
  a_hit_on_match: assert property (mem_valid && memory_response_enable
      && mem_addr[31:11] == window_base_pointer_q |=> window_hit_q)
    else $error("matching address missed");
  a_no_hit_disabled: assert property (!memory_response_enable |=> !window_hit_q)
    else $error("hit while memory response off");
  a_tenure_restart: assert property (frame_start |=> tenure_count_q == 8'h00)
    else $error("tenure count not cleared at frame");
  a_stop_on_grant: assert property (tenure_expired_q && xfer_active && gnt_n |=> xfer_stop_q)
    else $error("no stop after grant removed");
endmodule // cfg_hdr_chk

bind pci_config_header_regs cfg_hdr_chk u_chk (
  .clk(clk), .rstn(rstn), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
  .cfg_rdata_q(cfg_rdata_q), .cfg_ack_q(cfg_ack_q), .memory_response_enable(memory_response_enable),
  .mem_valid(mem_valid), .mem_addr(mem_addr), .window_hit_q(window_hit_q),
  .window_base_pointer_q(window_base_pointer_q), .frame_start(frame_start), .xfer_active(xfer_active),
  .gnt_n(gnt_n), .tenure_count_q(tenure_count_q), .tenure_expired_q(tenure_expired_q),
  .xfer_stop_q(xfer_stop_q)
);

/* File: dv/pci_config_header_regs_bench.sv */
/* self-checking bench for the header slice.
   assumes the host model drives the config port at the falling edge. */
`timescale 1ns/1ps
module pci_config_header_regs_bench;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  logic        clk = 1'b0, rstn = 1'b0, mem_valid = 1'b0, frame_start = 1'b0;
  logic        xfer_active = 1'b0, gnt_n = 1'b0, line_cmd_req = 1'b0;
  logic [31:0] mem_addr = 32'h0, rdata, q;
  logic        cfg_rd, cfg_wr, ack, mre, hit, ok, expired, stop;
  logic [7:0]  addr, count, line_size, limit;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic [10:0] offset;
  logic [20:0] ptr;
  int          errors = 0, checked = 0, cycles = 0;
  always #12.5 clk = ~clk;
  cfg_host_model u_host (.clk(clk), .cfg_ack_q(ack), .cfg_rdata_q(rdata), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(addr), .cfg_byte_en(be), .cfg_wdata(wdata), .memory_response_enable(mre));
  pci_config_header_regs #(.SILICON_REVISION(REV)) DUT (.clk(clk), .rstn(rstn), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(addr), .cfg_byte_en(be), .cfg_wdata(wdata), .cfg_rdata_q(rdata),
    .cfg_ack_q(ack), .memory_response_enable(mre), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .window_hit_q(hit), .window_offset_q(offset), .frame_start(frame_start), .xfer_active(xfer_active),
    .gnt_n(gnt_n), .line_cmd_req(line_cmd_req), .line_cmd_ok_q(ok), .tenure_count_q(count),
    .tenure_expired_q(expired), .xfer_stop_q(stop), .line_size_setting_q(line_size),
    .tenure_limit_q(limit), .window_base_pointer_q(ptr));
  // ==========================================================
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    u_host.access(1'b0, a, 4'hf, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    u_host.access(1'b1, a, b, d, q);
  endtask
  task automatic probe(input logic [31:0] a, input logic h, output logic [31:0] got);
    @(negedge clk);
    mem_valid = 1'b1;
    mem_addr = a;
    @(negedge clk);
    mem_valid = 1'b0;
    mem_addr = ~a;
    got = {20'h0, hit, offset};
  endtask
  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_fields;
    rd(8'h08, {24'h0c0010, REV});
    rd(8'h0c, 32'h0);
    wr(8'h08, 4'hf, '1);
    wr(8'h0c, 4'hf, '1);
    wr(8'h3c, 4'hf, '1);
    rd(8'h08, {24'h0c0010, REV});
    rd(8'h0c, 32'h0000_ffff);
    rd(8'h3c, 32'h0);
    $display("fields done");
  endtask
  task automatic t_base;
    rd(8'h10, 32'h0);
    wr(8'h10, 4'hf, '1);
    rd(8'h10, 32'hffff_f800);
    wr(8'h10, 4'hf, 32'h1234_5678);
    rd(8'h10, 32'h1234_5000);
    chk(ptr, 32'h1234_5000 >> 11);
    u_host.enable_memory(1'b1);
    probe(32'h1234_5024, 1'b1, q);
    chk(q, 32'h0000_0824);
    probe(32'h1234_5824, 1'b0, q);
    chk(q, 32'h0000_0024);
    u_host.enable_memory(1'b0);
    probe(32'h1234_57fc, 1'b0, q);
    chk(q, 32'h0000_07fc);
    $display("base done");
  endtask
  task automatic t_tenure;
    wr(8'h0c, 4'h2, 32'h0000_0300);
    chk(limit, 32'h3);
    chk(line_size, 32'hff);
    @(negedge clk);
    frame_start = 1'b1;
    xfer_active = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    chk(count, 32'h0);
    @(negedge clk);
    chk(count, 32'h1);
    @(negedge clk);
    chk(count, 32'h2);
    @(negedge clk);
    chk(count, 32'h3);
    chk(expired, 1'b0);
    @(negedge clk);
    chk(expired, 1'b1);
    chk(stop, 1'b0);
    gnt_n = 1'b1;
    @(negedge clk);
    chk(stop, 1'b1);
    xfer_active = 1'b0;
    gnt_n = 1'b0;
    line_cmd_req = 1'b1;
    @(negedge clk);
    chk(ok, 1'b1);
    wr(8'h0c, 4'h1, 32'h0);
    chk(line_size, 32'h0);
    chk(limit, 32'h3);
    @(negedge clk);
    chk(ok, 1'b0);
    line_cmd_req = 1'b0;
    $display("tenure done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    t_fields();
    t_base();
    t_tenure();
    results();
  end
endmodule // pci_config_header_regs_bench
